// [ocrc_checker.sv]
// Purpose: Continuously verifies the factory shadow registers by CRC-3.
// Assumes: Shadow data answers in the cycle after the address is issued.
// Notes:   The stored CRC sits in the low three bits of the last register.
`default_nettype none
module ocrc_checker
    import ocrc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       locked_i,
    input  wire logic [7:0] shadow_data_i,
    output logic            shadow_rd_o,
    output logic [4:0]      shadow_addr_o,
    output logic            factory_data_ok_o,
    output logic [7:0]      status_check_register_o,
    output logic            pass_done_o
);
    // ------------------------------------------------------------------
    // CRC step function
    // ------------------------------------------------------------------
    function automatic logic [2:0] crc_bit(input logic [2:0] c,
                                           input logic       d);
        logic fb;
        fb = c[2] ^ d;
        crc_bit = {c[1:0], 1'b0} ^ (fb ? OCRC_POLY : 3'h0);
    endfunction

    // The lock bit never enters the CRC, and in the last register the
    // stored CRC field is skipped as well, so those bits are left out
    // entirely rather than fed in as zeros.
    function automatic logic [2:0] crc_byte(input logic [2:0] c,
                                            input logic [7:0] d,
                                            input logic       crc_reg);
        logic [2:0] r;
        r = c;
        for (int i = 0; i < OCRC_LOCK_BIT; i++) begin
            if (!(crc_reg && OCRC_CRC_MASK[i])) begin
                r = crc_bit(r, d[i]);
            end
        end
        crc_byte = r;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    ocrc_state_t state_q;
    ocrc_state_t state_d;
    ocrc_req_t   req_q;
    ocrc_req_t   req_d;
    logic [2:0]  crc_q;
    logic [2:0]  crc_d;
    logic [2:0]  stored_q;
    logic [2:0]  stored_d;
    logic        data_vld_q;
    logic [4:0]  data_addr_q;
    logic        ok_q;
    logic        ok_d;
    logic        done_q;

    wire         is_crc_reg = (data_addr_q == OCRC_CRC_ADDR);
    // Feed is the raw byte; crc_byte leaves out the lock bit and stored CRC field.
    wire  [7:0]  feed       = shadow_data_i;
    wire  [2:0]  crc_next   = crc_byte(crc_q, feed, is_crc_reg);
    wire         last_addr  = (req_q.addr == OCRC_LAST_ADDR);
    wire         mismatch   = (crc_q != stored_q);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_d  = state_q;
        req_d    = req_q;
        crc_d    = crc_q;
        stored_d = stored_q;
        ok_d     = ok_q;
        if (data_vld_q) begin
            crc_d = crc_next;
            if (is_crc_reg) begin
                stored_d = shadow_data_i[2:0];
            end
        end
        case (state_q)
            OCRC_IDLE: begin
                req_d.rd_en = 1'b0;
                if (locked_i) begin
                    state_d     = OCRC_RUN;
                    req_d.rd_en = 1'b1;
                    req_d.addr  = OCRC_FIRST_ADDR;
                    crc_d       = OCRC_SEED;
                end
            end
            OCRC_RUN: begin
                if (last_addr) begin
                    req_d.rd_en = 1'b0;
                    state_d     = OCRC_CMP;
                end else begin
                    req_d.addr = req_q.addr + 5'h01;
                end
            end
            OCRC_CMP: begin
                // Last byte is folded in this cycle; compare next.
                if (!data_vld_q) begin
                    if (locked_i && mismatch) begin
                        ok_d = 1'b0;
                    end
                    state_d     = locked_i ? OCRC_RUN : OCRC_IDLE;
                    req_d.rd_en = locked_i;
                    req_d.addr  = OCRC_FIRST_ADDR;
                    crc_d       = OCRC_SEED;
                end
            end
            default: begin
                state_d     = OCRC_IDLE;
                req_d.rd_en = 1'b0;
            end
        endcase
        if (!locked_i && state_q != OCRC_CMP) begin
            state_d     = OCRC_IDLE;
            req_d.rd_en = 1'b0;
        end
    end

    wire cmp_now = (state_q == OCRC_CMP) && !data_vld_q;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state_q     <= OCRC_IDLE;
            req_q       <= '0;
            crc_q       <= OCRC_SEED;
            stored_q    <= 3'h0;
            data_vld_q  <= 1'b0;
            data_addr_q <= 5'h00;
            ok_q        <= 1'b1;
            done_q      <= 1'b0;
        end else begin
            state_q     <= state_d;
            req_q       <= req_d;
            crc_q       <= crc_d;
            stored_q    <= stored_d;
            data_vld_q  <= req_q.rd_en;
            data_addr_q <= req_q.addr;
            ok_q        <= ok_d & ok_q;
            done_q      <= cmp_now;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign shadow_rd_o       = req_q.rd_en;
    assign shadow_addr_o     = req_q.addr;
    assign factory_data_ok_o = ok_q;
    assign pass_done_o       = done_q;
    always_comb begin
        status_check_register_o = OCRC_SC_OTHER;
        status_check_register_o[OCRC_OK_BIT] = ok_q;
    end
endmodule
`default_nettype wire

// [ocrc_pkg.sv]
// Purpose: Constants and types for the fuse shadow CRC checker.
// Assumes: Shadow registers are 8 bits wide and read one per cycle.
// Notes:   Address range and CRC field location are parameters of choice.
`default_nettype none
package ocrc_pkg;
    localparam int unsigned OCRC_AW          = 5;
    localparam int unsigned OCRC_DW          = 8;
    localparam logic [4:0]  OCRC_FIRST_ADDR  = 5'h00;
    localparam logic [4:0]  OCRC_LAST_ADDR   = 5'h0b;
    localparam logic [4:0]  OCRC_CRC_ADDR    = 5'h0b;
    localparam logic [7:0]  OCRC_CRC_MASK    = 8'h07;
    localparam logic [7:0]  OCRC_LOCK_MASK   = 8'h80;
    localparam int unsigned OCRC_LOCK_BIT    = 7;
    localparam logic [2:0]  OCRC_SEED        = 3'h7;
    localparam logic [2:0]  OCRC_POLY        = 3'h3;
    localparam int unsigned OCRC_OK_BIT      = 2;
    localparam logic [7:0]  OCRC_SC_ADDR     = 8'h0c;
    localparam logic [7:0]  OCRC_SC_OTHER    = 8'h00;

    typedef enum logic [1:0] {
        OCRC_IDLE = 2'h0,
        OCRC_RUN  = 2'h1,
        OCRC_CMP  = 2'h3
    } ocrc_state_t;

    typedef struct packed {
        logic       rd_en;
        logic [4:0] addr;
    } ocrc_req_t;
endpackage
`default_nettype wire

// [ocrc_sva.sv]
// Purpose: Port checks for the shadow CRC checker.
// Assumes: Timing as in the hand-over walk.
// Notes:   Bound into every checker instance.
`default_nettype none
module ocrc_sva
    import ocrc_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       nrst_i,
    input wire logic       locked_i,
    input wire logic [7:0] shadow_data_i,
    input wire logic       shadow_rd_o,
    input wire logic [4:0] shadow_addr_o,
    input wire logic       factory_data_ok_o,
    input wire logic [7:0] status_check_register_o,
    input wire logic       pass_done_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    AST_STAT: assert property (status_check_register_o ==
        {5'h00, factory_data_ok_o, 2'h0}) else $error("status bad");
    AST_STICKY: assert property (!factory_data_ok_o |=>
        !factory_data_ok_o) else $error("ok flag rose");
    AST_OKFALL: assert property ($fell(factory_data_ok_o) |->
        pass_done_o) else $error("ok fell off a pass end");
    AST_FIRST: assert property ($rose(shadow_rd_o) |->
        shadow_addr_o == OCRC_FIRST_ADDR) else $error("bad start");
    AST_ADDR: assert property (shadow_rd_o && $past(shadow_rd_o) |->
        shadow_addr_o == $past(shadow_addr_o) + 5'h01)
        else $error("address not ascending");
    AST_LAST: assert property (shadow_rd_o &&
        shadow_addr_o == OCRC_LAST_ADDR |=> !shadow_rd_o)
        else $error("read past end");
    AST_UNLK: assert property ((!locked_i)[*3] |->
        $stable(factory_data_ok_o)) else $error("unlocked report");
    AST_GAP: assert property (shadow_rd_o && locked_i &&
        shadow_addr_o == OCRC_LAST_ADDR ##1 locked_i ##1 locked_i |=>
        shadow_rd_o &&
        shadow_addr_o == OCRC_FIRST_ADDR) else $error("no restart");
endmodule
bind ocrc_checker ocrc_sva i_ocrc_sva (.clk_i(clk_i), .nrst_i(nrst_i),
    .locked_i(locked_i), .shadow_data_i(shadow_data_i),
    .shadow_rd_o(shadow_rd_o), .shadow_addr_o(shadow_addr_o),
    .factory_data_ok_o(factory_data_ok_o), .pass_done_o(pass_done_o),
    .status_check_register_o(status_check_register_o));
`default_nettype wire

// [ocrc_shadow_model.sv]
// Purpose: Shadow register bank facing the checker.
// Assumes: Data returns the cycle after the address.
// Notes:   Idle data toggles so stale bytes never match.
`default_nettype none
module ocrc_shadow_model (
    input  wire logic       clk_i,
    input  wire logic       rd_i,
    input  wire logic [4:0] addr_i,
    output logic      [7:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem_q [32];
    initial data_o = 8'h00;
    always @(posedge clk_i)
        data_o <= rd_i ? mem_q[addr_i] : ~data_o;
endmodule
`default_nettype wire

// [tb_top.sv]
// Purpose: Self-checking bench for the shadow CRC checker.
// Assumes: The shadow model serves the reads.
// Notes:   The expected CRC is built here from the generator.
`default_nettype none
module tb_top
    import ocrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 0, nrst = 0, lock = 0, rd, ok, pd;
    logic [4:0] ad;
    logic [7:0] dat, st;
    int         failures = 0, compares = 0;
    initial forever #2.5 clk = ~clk;
    ocrc_checker i_ocrc_checker (.clk_i(clk), .nrst_i(nrst),
        .locked_i(lock), .shadow_data_i(dat), .shadow_rd_o(rd),
        .shadow_addr_o(ad), .factory_data_ok_o(ok),
        .status_check_register_o(st), .pass_done_o(pd));
    ocrc_shadow_model i_ocrc_shadow_model (.clk_i(clk), .rd_i(rd),
        .addr_i(ad), .data_o(dat));
    task automatic chk(logic [7:0] g, logic [7:0] e);
        compares++;
        if (g !== e) begin
            failures++;
            $display("unexpected t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic fill(logic [7:0] base, logic bad, logic [7:0] lk);
        logic [2:0] c;
        logic [7:0] d;
        c = OCRC_SEED;
        for (int a = 0; a < 12; a++) begin
            d = base + 8'(a * 37) ^ lk;
            i_ocrc_shadow_model.mem_q[a] = d;
            for (int b = 0; b < 7; b++)
                if (a < 11 || b > 2)
                    c = {c[1:0], 1'b0} ^ (OCRC_POLY & {3{c[2] ^ d[b]}});
        end
        i_ocrc_shadow_model.mem_q[11][2:0] = c ^ {2'h0, bad};
    endtask
    task automatic passes(int n, logic lk);
        @(posedge clk) lock <= lk;
        repeat (n) begin
            for (int i = 0; i < 40 && pd !== 1'b1; i++) @(negedge clk);
            chk(pd, 1'b1);
            @(negedge clk);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #10000;
        failures++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1;
        @(negedge clk);
        chk(st, 8'h04);
        fill(8'h81, 0, 8'h00);
        passes(3, 1);
        chk(ok, 1'b1);
        $display("good data test done");
        fill(8'h81, 0, 8'h80);
        passes(2, 1);
        chk(ok, 1'b1);
        @(posedge clk) lock <= 0;
        fill(8'h13, 1, 8'h00);
        repeat (60) @(negedge clk);
        chk(ok, 1'b1);
        passes(3, 1);
        chk(st, 8'h00);
        fill(8'h13, 0, 8'h00);
        passes(2, 1);
        chk(ok, 1'b0);
        @(posedge clk) nrst <= 0;
        repeat (12) @(posedge clk);
        nrst <= 1;
        @(negedge clk);
        chk(ok, 1'b1);
        $display("bad data test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
